// ===== sxa_alu_regs.svh
// register offsets, field positions, reset values of the alu datapath
// assumes inclusion by bare name from the design file that needs it
`ifndef SXA_ALU_REGS_SVH
`define SXA_ALU_REGS_SVH

// register offsets on the plain register port
`define SXA_ADDR_ACC 4'h0
`define SXA_ADDR_STATUS 4'h1
`define SXA_ADDR_RESULT 4'h2
`define SXA_ADDR_COUNT 4'h3

// status register field positions
`define SXA_ST_CARRY 0
`define SXA_ST_NIBBLE 1
`define SXA_ST_ZERO 2

// reset values
`define SXA_ACC_RESET 8'h00
`define SXA_STATUS_RESET 3'h0
`define SXA_RESULT_RESET 8'h00
`define SXA_COUNT_RESET 8'h00
`define SXA_WB_ADDR_RESET 7'h00
`define SXA_WB_DATA_RESET 8'h00
`define SXA_RDATA_RESET 8'h00

`endif

// ===== sxa_pkg.sv
// types shared by the alu datapath and its surroundings
// assumes the decoder sends one request per cycle at most
package sxa_pkg;

	// operations served by this datapath
	typedef enum logic [1:0] {
		sxa_op_sub,
		sxa_op_xor_mem,
		sxa_op_swap,
		sxa_op_xor_imm
	} sxa_op_t;

	// one request from the instruction decoder
	typedef struct packed {
		sxa_op_t op;
		logic target;
		logic [6:0] mem_addr;
		logic [7:0] imm;
	} sxa_req_t;

	// arithmetic status flags kept by the datapath
	typedef struct packed {
		logic zero;
		logic nibble_borrow_not;
		logic carry;
	} sxa_flags_t;

endpackage

// ===== sxa_alu.sv
// accumulator datapath: subtract, xor (memory and immediate), nibble exchange
// assumes decoder, operand fetch and register port share sys_clk; no sync needed
`timescale 1ns/1ps
`include "sxa_alu_regs.svh"

// Overview of operation
// - subtract_acc_from_memory computes memory operand minus accumulator, operand from a 7-bit address.
// - target select 0 sends a memory-operand result to the accumulator, 1 back to the operand.
// - subtract sets carry unless acc exceeds operand, and nibble_borrow_not likewise on low nibbles.
// - xor_acc_with_memory xors accumulator and operand, routes by target, touches only zero.
// - nibble_exchange swaps operand nibbles and routes the result by target.
// - nibble_exchange leaves carry, nibble_borrow_not and zero as they were.
// - xor_immediate xors accumulator with an 8-bit immediate, writes acc and updates zero.
module sxa_alu #(
	parameter int DATA_W = 8,
	parameter int FADDR_W = 7
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// request from the decoder with its fetched operand
	input wire logic op_valid,
	input wire sxa_pkg::sxa_req_t op_req,
	input wire logic [7:0] mem_operand,
	// write back to the register file
	output logic mem_wr,
	output logic [6:0] mem_addr,
	output logic [7:0] mem_wdata,
	// core state
	output logic [7:0] acc,
	output sxa_pkg::sxa_flags_t flags,
	output logic op_done
);
	import sxa_pkg::*;

	// nibble logic and field widths are fixed by the instruction format
	if (DATA_W != 8 || FADDR_W != 7) begin : g_width_check
		$error("sxa_alu: only DATA_W=8 and FADDR_W=7 are supported");
	end

	logic [7:0] next_result;
	sxa_flags_t next_flags;
	logic to_memory;
	logic [8:0] full_diff;
	logic [4:0] low_diff;
	logic [7:0] last_result;
	logic [7:0] op_count;
	// the write-back path has no forwarding: the decoder must refetch after
	// a memory-targeted result before it reads that address again

	// borrow out of a widened subtract gives the carry without a comparator
	assign full_diff = {1'b0, mem_operand} - {1'b0, acc};
	assign low_diff = {1'b0, mem_operand[3:0]} - {1'b0, acc[3:0]};

	// result and flag selection per operation
	always_comb begin
		next_result = mem_operand;
		next_flags = flags;
		to_memory = 1'b0;
		case (op_req.op)
			sxa_op_sub: begin
				next_result = full_diff[7:0];
				next_flags.carry = ~full_diff[8];
				next_flags.nibble_borrow_not = ~low_diff[4];
				next_flags.zero = (full_diff[7:0] == 8'h00);
				to_memory = op_req.target;
			end
			sxa_op_xor_mem: begin
				next_result = acc ^ mem_operand;
				next_flags.zero = ((acc ^ mem_operand) == 8'h00);
				to_memory = op_req.target;
			end
			sxa_op_swap: begin
				next_result = {mem_operand[3:0], mem_operand[7:4]};
				next_flags = flags;
				to_memory = op_req.target;
			end
			sxa_op_xor_imm: begin
				next_result = acc ^ op_req.imm;
				next_flags.zero = ((acc ^ op_req.imm) == 8'h00);
				to_memory = 1'b0;
			end
			default: begin
				next_result = mem_operand;
				next_flags = flags;
				to_memory = 1'b0;
			end
		endcase
	end

	// accumulator: an executing accumulator-targeted operation wins over a software write
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc <= `SXA_ACC_RESET;
		end else if (op_valid && !to_memory) begin
			acc <= next_result;
		end else if (reg_wr && reg_addr == `SXA_ADDR_ACC) begin
			acc <= reg_wdata;
		end
	end

	// status flags: same priority, hardware update beats software write
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags <= `SXA_STATUS_RESET;
		end else if (op_valid) begin
			flags <= next_flags;
		end else if (reg_wr && reg_addr == `SXA_ADDR_STATUS) begin
			flags.carry <= reg_wdata[`SXA_ST_CARRY];
			flags.nibble_borrow_not <= reg_wdata[`SXA_ST_NIBBLE];
			flags.zero <= reg_wdata[`SXA_ST_ZERO];
		end
	end

	// write back toward the register file, one-cycle strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_wr <= 1'b0;
			mem_addr <= `SXA_WB_ADDR_RESET;
			mem_wdata <= `SXA_WB_DATA_RESET;
		end else begin
			mem_wr <= op_valid && to_memory;
			if (op_valid && to_memory) begin
				mem_addr <= op_req.mem_addr;
				mem_wdata <= next_result;
			end
		end
	end

	// completion pulse and last result for software inspection
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_done <= 1'b0;
			last_result <= `SXA_RESULT_RESET;
		end else begin
			op_done <= op_valid;
			if (op_valid) begin
				last_result <= next_result;
			end
		end
	end

	// executed-operation counter; counting wins over a clearing write
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_count <= `SXA_COUNT_RESET;
		end else if (op_valid) begin
			op_count <= op_count + 8'h01; // wraps, software samples deltas
		end else if (reg_wr && reg_addr == `SXA_ADDR_COUNT) begin
			op_count <= `SXA_COUNT_RESET;
		end
	end

	// read data only in the cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `SXA_RDATA_RESET;
		end else if (reg_rd) begin
			case (reg_addr)
				`SXA_ADDR_ACC: reg_rdata <= acc;
				`SXA_ADDR_STATUS: reg_rdata <= {5'h00, flags};
				`SXA_ADDR_RESULT: reg_rdata <= last_result;
				`SXA_ADDR_COUNT: reg_rdata <= op_count;
				default: reg_rdata <= 8'h00; // unmapped reads as zero
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// checks on the datapath, all on sys_clk
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence sub_to_acc_s;
		op_valid && op_req.op == sxa_op_sub && !op_req.target;
	endsequence

	sub_result_a: assert property (
		sub_to_acc_s |=> acc == 8'($past(mem_operand) - $past(acc)))
		else $error("subtract result wrong in accumulator");

	mem_target_a: assert property (
		op_valid && op_req.op != sxa_op_xor_imm && op_req.target
		&& !(reg_wr && reg_addr == `SXA_ADDR_ACC) // a same-cycle acc write may land
		|=> mem_wr && mem_addr == $past(op_req.mem_addr) && $stable(acc))
		else $error("memory target not written back");

	acc_target_a: assert property (
		op_valid && !op_req.target |=> !mem_wr ##1 !mem_wr || $past(op_valid))
		else $error("accumulator target wrote memory");

	sub_carry_a: assert property (
		op_valid && op_req.op == sxa_op_sub
		|=> flags.carry == ($past(acc) <= $past(mem_operand)))
		else $error("subtract carry wrong");

	sub_nibble_a: assert property (
		op_valid && op_req.op == sxa_op_sub
		|=> flags.nibble_borrow_not == ($past(acc[3:0]) <= $past(mem_operand[3:0])))
		else $error("subtract nibble flag wrong");

	xor_mem_a: assert property (
		op_valid && op_req.op == sxa_op_xor_mem && op_req.target
		|=> mem_wdata == ($past(acc) ^ $past(mem_operand)) && $stable(flags.carry)
		&& $stable(flags.nibble_borrow_not))
		else $error("xor with memory wrong");

	swap_result_a: assert property (
		op_valid && op_req.op == sxa_op_swap && op_req.target
		|=> mem_wdata == {$past(mem_operand[3:0]), $past(mem_operand[7:4])})
		else $error("nibble exchange result wrong");

	swap_flags_a: assert property (
		op_valid && op_req.op == sxa_op_swap |=> $stable(flags))
		else $error("nibble exchange changed flags");

	xor_imm_a: assert property (
		op_valid && op_req.op == sxa_op_xor_imm
		|=> acc == ($past(acc) ^ $past(op_req.imm)) && !mem_wr)
		else $error("xor immediate wrong");

	zero_flag_a: assert property (
		op_valid && op_req.op != sxa_op_swap
		|=> flags.zero == ((mem_wr ? mem_wdata : acc) == 8'h00))
		else $error("zero flag does not match result");

	read_timing_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");

	sub_mem_a: assert property (
		op_valid && op_req.op == sxa_op_sub && op_req.target
		|=> mem_wdata == 8'($past(mem_operand) - $past(acc)))
		else $error("subtract result wrong in memory");

	mem_wr_source_a: assert property (
		mem_wr |-> $past(op_valid) && $past(op_req.target)
		&& $past(op_req.op) != sxa_op_xor_imm)
		else $error("write back without a memory-targeted operation");

	xor_acc_a: assert property (
		op_valid && op_req.op == sxa_op_xor_mem && !op_req.target
		|=> acc == ($past(acc) ^ $past(mem_operand)))
		else $error("xor with memory wrong in accumulator");

	swap_acc_a: assert property (
		op_valid && op_req.op == sxa_op_swap && !op_req.target
		|=> acc == {$past(mem_operand[3:0]), $past(mem_operand[7:4])})
		else $error("nibble exchange wrong in accumulator");

	// register port and bookkeeping
	op_done_a: assert property (
		op_done == $past(op_valid))
		else $error("completion pulse out of step");

	idle_hold_a: assert property (
		!op_valid && !reg_wr |=> $stable(acc) && $stable(flags))
		else $error("state changed with no request");

	acc_write_a: assert property (
		reg_wr && reg_addr == `SXA_ADDR_ACC && !op_valid |=> acc == $past(reg_wdata))
		else $error("accumulator write lost");

	status_write_a: assert property (
		reg_wr && reg_addr == `SXA_ADDR_STATUS && !op_valid
		|=> flags == $past(reg_wdata[2:0]))
		else $error("status write lost");

	read_acc_a: assert property (
		reg_rd && reg_addr == `SXA_ADDR_ACC |=> reg_rdata == $past(acc))
		else $error("accumulator read wrong");

	read_status_a: assert property (
		reg_rd && reg_addr == `SXA_ADDR_STATUS |=> reg_rdata == {5'h00, $past(flags)})
		else $error("status read wrong");

	read_unmapped_a: assert property (
		reg_rd && reg_addr > `SXA_ADDR_COUNT |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	count_step_a: assert property (
		op_valid |=> op_count == 8'($past(op_count) + 8'h01))
		else $error("operation count did not step");

	count_clear_a: assert property (
		reg_wr && reg_addr == `SXA_ADDR_COUNT && !op_valid
		|=> op_count == `SXA_COUNT_RESET)
		else $error("operation count not cleared");

	result_reg_a: assert property (
		op_valid |=> last_result == (mem_wr ? mem_wdata : acc))
		else $error("last result does not match the written value");

	// main scenarios
	sub_zero_c: cover property (
		op_valid && op_req.op == sxa_op_sub ##1 flags.zero && flags.carry);
	sub_borrow_c: cover property (
		op_valid && op_req.op == sxa_op_sub ##1 !flags.carry && flags.nibble_borrow_not);
	swap_mem_c: cover property (
		op_valid && op_req.op == sxa_op_swap && op_req.target ##1 mem_wr);
	back_to_back_c: cover property (
		op_valid && op_req.op == sxa_op_xor_imm ##1 op_valid && op_req.op == sxa_op_xor_mem);
	count_clear_c: cover property (
		reg_wr && reg_addr == `SXA_ADDR_COUNT ##1 op_count == 8'h00);

endmodule

// ===== sxa_file_model.sv
// register file model feeding operands to the datapath
// assumes no read of an address in the cycle after its write back
`timescale 1ns/1ps
module sxa_file_model (
	// clock
	input wire logic sys_clk,
	// operand fetch
	input wire logic [6:0] rd_addr,
	output logic [7:0] mem_operand,
	// write back
	input wire logic mem_wr,
	input wire logic [6:0] mem_addr,
	input wire logic [7:0] mem_wdata
);
	logic [7:0] mem [128];

	// known fill so every operand is predictable
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i * 29);
		end
	end

	// lands one edge late; no forwarding, like the real file
	always @(posedge sys_clk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end

	// fetch is combinational
	assign mem_operand = mem[rd_addr];
endmodule

// ===== subtract_xor_swap_alu_ops_tb.sv
// self-checking bench: register port and the four operations
// assumes the file model holds i*29 at address i after load
`timescale 1ns/1ps
`include "sxa_alu_regs.svh"
module subtract_xor_swap_alu_ops_tb;
	import sxa_pkg::*;
	logic sys_clk, reset_n, reg_wr, reg_rd, op_valid, mem_wr, op_done;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, mem_operand, mem_wdata, acc, acc_m;
	logic [6:0] mem_addr;
	sxa_req_t op_req;
	sxa_flags_t flags, f_m;
	logic [7:0] shadow [128];
	int mismatches, n_compared;
	logic [7:0] accs [5] = '{8'h57, 8'h58, 8'h50, 8'h67, 8'hff};

	sxa_alu sxa_alu_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.op_valid(op_valid), .op_req(op_req), .mem_operand(mem_operand), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
		.op_done(op_done));
	sxa_file_model sxa_file_model_inst (.sys_clk(sys_clk), .rd_addr(op_req.mem_addr),
		.mem_operand(mem_operand), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata));

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata, exp);
	endtask

	// one operation; expectations come from the bench's own model
	task automatic do_op(input sxa_op_t o, input logic t, input logic [6:0] a,
		input logic [7:0] k);
		logic [7:0] v;
		logic [7:0] res;
		logic to_mem;
		v = shadow[a];
		to_mem = t && (o != sxa_op_xor_imm);
		case (o)
			sxa_op_sub: begin
				res = v - acc_m;
				f_m.carry = acc_m <= v;
				f_m.nibble_borrow_not = acc_m[3:0] <= v[3:0];
			end
			sxa_op_xor_mem: res = acc_m ^ v;
			sxa_op_swap: res = {v[3:0], v[7:4]};
			default: res = acc_m ^ k;
		endcase
		if (o != sxa_op_swap) begin
			f_m.zero = res == 8'h00;
		end
		if (to_mem) begin
			shadow[a] = res;
		end else begin
			acc_m = res;
		end
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_req <= '{op: o, target: t, mem_addr: a, imm: k};
		@(posedge sys_clk);
		op_valid <= 1'b0;
		#1;
		check("op_done", {7'h0, op_done}, 8'h01);
		check("mem_wr", {7'h0, mem_wr}, {7'h0, to_mem});
		check("acc", acc, acc_m);
		check("flags", {5'h0, flags}, {5'h0, f_m});
		if (to_mem) begin
			check("mem_addr", {1'b0, mem_addr}, {1'b0, a});
			check("mem_wdata", mem_wdata, res);
		end
	endtask

	task automatic finish_test();
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		finish_test();
	end

	// main sequence
	initial begin
		reset_n = 1'b0;
		{reg_wr, reg_rd, op_valid, reg_addr, reg_wdata} = '0;
		op_req = '0;
		acc_m = 8'h00;
		f_m = '0;
		for (int i = 0; i < 128; i++) begin
			shadow[i] = 8'(i * 29);
		end
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		reg_read(`SXA_ADDR_ACC, 8'h00);
		reg_read(`SXA_ADDR_STATUS, 8'h00);
		reg_read(4'hf, 8'h00);
		// subtract around equal, nibble and full borrow points of 8'h57
		foreach (accs[i]) begin
			reg_write(`SXA_ADDR_ACC, accs[i]);
			acc_m = accs[i];
			do_op(sxa_op_sub, 1'b0, 7'd3, 8'h00);
		end
		do_op(sxa_op_sub, 1'b1, 7'd127, 8'h00);
		acc_m = shadow[16];
		reg_write(`SXA_ADDR_ACC, acc_m);
		do_op(sxa_op_xor_mem, 1'b0, 7'd16, 8'h00);
		do_op(sxa_op_xor_mem, 1'b1, 7'd17, 8'h00);
		// flags all set so a swap that touches them shows
		reg_write(`SXA_ADDR_STATUS, 8'h07);
		f_m = 3'h7;
		do_op(sxa_op_swap, 1'b0, 7'd32, 8'h00);
		do_op(sxa_op_swap, 1'b1, 7'd126, 8'h00);
		do_op(sxa_op_xor_imm, 1'b1, 7'd5, acc_m);
		do_op(sxa_op_xor_imm, 1'b0, 7'd5, 8'hff);
		reg_read(`SXA_ADDR_ACC, acc_m);
		reg_read(`SXA_ADDR_STATUS, {5'h00, f_m});
		reg_read(`SXA_ADDR_RESULT, acc_m);
		// twelve operations ran since reset
		reg_read(`SXA_ADDR_COUNT, 8'h0c);
		reg_write(`SXA_ADDR_COUNT, 8'h5a);
		reg_read(`SXA_ADDR_COUNT, 8'h00);
		finish_test();
	end
endmodule
